//--- core/adc_reset_reference_control.sv
// top: reset, reference and data-ready housekeeping for the converter
`timescale 1ns/10ps
module adc_reset_reference_control
  import adc_ctl_pkg::*;
#(
  parameter int PORCYCLES = POR_CYC
)(
  input  wire logic                     mclk,
  input  wire logic                     nrst,
  input  wire logic                     hardRstPinN,
  input  wire logic                     avddGood,
  input  wire logic                     dvddGood,
  input  wire cfg_wr_t                  cfgWrite,
  input  wire sample_t                  sampleIn,
  input  wire logic                     sdoData,
  output logic [CFG_W-1:0]              first_configuration_word,
  output logic [7:0]                    reference_tempco_trim,
  output logic                          ext_reference_select,
  output logic                          refOutEnable,
  output logic                          refDiffInput,
  output logic                          autoZeroPhase,
  output logic                          biasOn,
  output logic                          porDone,
  output logic                          sdoOut,
  output logic                          sdoOeN,
  output logic                          data_ready_pin,
  output logic                          dataReadyOeN,
  output logic [NUM_CH*DATA_W-1:0]      chanCodes,
  output logic [NUM_CH*CMP_W-1:0]       cmpStates
);
  // three-stage pin synchronisers
  logic [2:0] rstSync_ff;
  logic [2:0] avSync_ff;
  logic [2:0] dvSync_ff;
  logic       hardRst_ff;
  logic       suppliesOk_ff;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstSync_ff <= 3'h0;
      avSync_ff  <= 3'h0;
      dvSync_ff  <= 3'h0;
    end else begin
      rstSync_ff <= {rstSync_ff[1:0], hardRstPinN};
      avSync_ff  <= {avSync_ff[1:0], avddGood};
      dvSync_ff  <= {dvSync_ff[1:0], dvddGood};
    end
  end

  // a change counts only once stages two and three agree
  wire rstAgree = (rstSync_ff[1] == rstSync_ff[2]);
  wire avAgree  = (avSync_ff[1] == avSync_ff[2]);
  wire dvAgree  = (dvSync_ff[1] == dvSync_ff[2]);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hardRst_ff    <= 1'b1;
      suppliesOk_ff <= 1'b0;
    end else begin
      if (rstAgree) begin
        hardRst_ff <= ~rstSync_ff[2];
      end
      if (avAgree && dvAgree) begin
        suppliesOk_ff <= avSync_ff[2] & dvSync_ff[2];
      end
    end
  end

  // power-on delay counter; restarts if either supply drops
  localparam int PW = $clog2(PORCYCLES + 1);
  logic [PW-1:0] porCnt_ff;
  logic          porDone_ff;
  wire           porHit = (porCnt_ff == PW'(PORCYCLES - 1));

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      porCnt_ff  <= '0;
      porDone_ff <= 1'b0;
    end else if (!suppliesOk_ff) begin
      porCnt_ff  <= '0;
      porDone_ff <= 1'b0;
    end else if (!porDone_ff) begin
      porCnt_ff  <= porCnt_ff + PW'(1);
      porDone_ff <= porHit;
    end
  end

  // configuration word; writes dropped in hard reset or before power-up
  logic [CFG_W-1:0] cfg_ff;
  wire              wrOk = cfgWrite.en & ~hardRst_ff & porDone_ff;
  wire [CFG_W-1:0]  nxt_cfg = wrOk ? cfgWrite.data : cfg_ff;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_ff <= CFG_RESET;
    end else if (hardRst_ff || !porDone_ff) begin
      cfg_ff <= CFG_RESET;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  wire [7:0] trim   = cfg_ff[TRIM_MSB:TRIM_LSB];
  wire       extSel = cfg_ff[EXTREF_BIT];
  wire [2:0] oversampling_ratio    = cfg_ff[OSR_MSB:OSR_LSB];

  // reference buffer auto-zero chopping, divided from mclk
  logic [AZ_DIV-1:0] azCnt_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      azCnt_ff <= '0;
    end else begin
      azCnt_ff <= azCnt_ff + AZ_DIV'(1);
    end
  end

  // control sequencer: wait for power-up, settle filters, then run
  ctl_state_t          state_ff;
  ctl_state_t          nxt_state;
  logic [SETTLE_W-1:0] settleCnt_ff;
  wire                 settleDone = (settleCnt_ff == settle_cycles(oversampling_ratio));
  wire                 running    = (state_ff == ST_RUN);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POR: begin
        if (porDone_ff && !hardRst_ff) begin
          nxt_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settleDone) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_POR;
      end
    endcase
    if (!porDone_ff || hardRst_ff) begin
      nxt_state = ST_POR;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_POR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // settling count restarts from zero on every restart
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      settleCnt_ff <= '0;
    end else if (state_ff != ST_SETTLE) begin
      settleCnt_ff <= '0;
    end else if (!settleDone) begin
      settleCnt_ff <= settleCnt_ff + SETTLE_W'(1);
    end
  end

  // samples only load once filters are settled
  wire loadSample = running & sampleIn.valid;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gCh
      chan_format uFmt (
        .mclk    (mclk),
        .nrst    (nrst),
        .hardRst (hardRst_ff),
        .load    (loadSample && (sampleIn.chan == 3'(g))),
        .oversampling_ratio     (oversampling_ratio),
        .rawCode (sampleIn.code),
        .code    (chanCodes[g*DATA_W +: DATA_W]),
        .cmpOut  (cmpStates[g*CMP_W +: CMP_W])
      );
    end
  endgenerate

  // next values of the pins, named wires so each output flop stays plain
  wire nxt_drPulse = ~(loadSample & (sampleIn.chan == 3'(NUM_CH - 1)));
  wire nxt_oeN     = hardRst_ff | ~porDone_ff;
  wire nxt_refOe   = ~extSel;
  wire nxt_refDiff = extSel;

  // data-ready pulse; idles high so leaving reset never looks like a pulse
  logic drPulse_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      drPulse_ff <= 1'b1;
    end else begin
      drPulse_ff <= nxt_drPulse;
    end
  end

  // serial data and the shared enable; both pins float (enable high) in hard reset
  logic sdo_ff;
  logic oeN_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sdo_ff <= 1'b0;
      oeN_ff <= 1'b1;
    end else begin
      sdo_ff <= sdoData;
      oeN_ff <= nxt_oeN;
    end
  end

  // reference pin mode; pins always match the select bit, internal by default
  logic refOe_ff;
  logic refDiff_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      refOe_ff   <= 1'b1;
      refDiff_ff <= 1'b0;
    end else begin
      refOe_ff   <= nxt_refOe;
      refDiff_ff <= nxt_refDiff;
    end
  end

  // auto-zero phase and bias; bias ignores hard reset so restart is quick
  logic az_ff;
  logic bias_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      az_ff   <= 1'b0;
      bias_ff <= 1'b0;
    end else begin
      az_ff   <= azCnt_ff[AZ_DIV-1];
      bias_ff <= porDone_ff;
    end
  end

  // config views for the host, one flop stage behind the stored word
  logic [CFG_W-1:0] cfgOut_ff;
  logic [7:0]       trimOut_ff;
  logic             extOut_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfgOut_ff  <= CFG_RESET;
      trimOut_ff <= TRIM_RESET;
      extOut_ff  <= 1'b0;
    end else begin
      cfgOut_ff  <= cfg_ff;
      trimOut_ff <= trim;
      extOut_ff  <= extSel;
    end
  end

  assign data_ready_pin           = drPulse_ff;
  assign dataReadyOeN             = oeN_ff;
  assign sdoOut                   = sdo_ff;
  assign sdoOeN                   = oeN_ff;
  assign refOutEnable             = refOe_ff;
  assign refDiffInput             = refDiff_ff;
  assign autoZeroPhase            = az_ff;
  assign biasOn                   = bias_ff;
  assign porDone                  = porDone_ff;
  assign first_configuration_word = cfgOut_ff;
  assign reference_tempco_trim    = trimOut_ff;
  assign ext_reference_select     = extOut_ff;
endmodule

//--- core/adc_ctl_pkg.sv
// package: constants, types and field layout for the converter control block
package adc_ctl_pkg;
  localparam int          NUM_CH         = 8;
  localparam int          DATA_W         = 24;
  localparam int          CMP_W          = 4;
  localparam int          CFG_W          = 24;
  localparam logic [3:0]  CMP_RESET      = 4'h3;
  localparam logic [7:0]  TRIM_RESET     = 8'h50;
  localparam int          TRIM_LSB       = 0;
  localparam int          TRIM_MSB       = 7;
  localparam int          EXTREF_BIT     = 8;
  localparam int          OSR_LSB        = 9;
  localparam int          OSR_MSB        = 11;
  localparam logic [2:0]  OSR_RESET      = 3'h3;
  localparam logic [23:0] CFG_RESET      = 24'h000650;
  localparam logic [23:0] CODE_ZERO      = 24'h000000;
  localparam int          CLK_MHZ        = 40;
  localparam int          POR_US         = 50;
  localparam int          POR_CYC        = POR_US * CLK_MHZ;
  localparam int          AZ_DIV         = 4;
  localparam int          SETTLE_W       = 13;

  typedef struct packed {
    logic       valid;
    logic [2:0] chan;
    logic [DATA_W-1:0] code;
  } sample_t;

  typedef struct packed {
    logic       en;
    logic [CFG_W-1:0] data;
  } cfg_wr_t;

  typedef enum logic [1:0] {
    ST_POR    = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN    = 2'b10
  } ctl_state_t;

  // settling time in master-clock units for each ratio code
  function automatic logic [SETTLE_W-1:0] settle_cycles(input logic [2:0] oversampling_ratio);
    case (oversampling_ratio)
      3'h0:    settle_cycles = 13'h0060;
      3'h1:    settle_cycles = 13'h00C0;
      3'h2:    settle_cycles = 13'h0180;
      3'h3:    settle_cycles = 13'h0300;
      3'h4:    settle_cycles = 13'h0600;
      3'h5:    settle_cycles = 13'h0800;
      3'h6:    settle_cycles = 13'h0C00;
      default: settle_cycles = 13'h1400;
    endcase
  endfunction

  // mask of kept bits: resolution 17,20,23 then 24
  function automatic logic [DATA_W-1:0] res_mask(input logic [2:0] oversampling_ratio);
    case (oversampling_ratio)
      3'h0:    res_mask = 24'hFFFF80;
      3'h1:    res_mask = 24'hFFFFF0;
      3'h2:    res_mask = 24'hFFFFFE;
      default: res_mask = 24'hFFFFFF;
    endcase
  endfunction
endpackage

//--- core/chan_format.sv
// per-channel result formatting and comparator state
`timescale 1ns/10ps
module chan_format
  import adc_ctl_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              hardRst,
  input  wire logic              load,
  input  wire logic [2:0]        oversampling_ratio,
  input  wire logic [DATA_W-1:0] rawCode,
  output logic      [DATA_W-1:0] code,
  output logic      [CMP_W-1:0]  cmpOut
);
  logic [DATA_W-1:0] code_ff;
  logic [CMP_W-1:0]  cmp_ff;
  wire  [DATA_W-1:0] nxt_code = rawCode & res_mask(oversampling_ratio);

  // output buffer; hard reset clears it and parks the comparator
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      code_ff <= CODE_ZERO;
      cmp_ff  <= CMP_RESET;
    end else if (hardRst) begin
      code_ff <= CODE_ZERO;
      cmp_ff  <= CMP_RESET;
    end else begin
      if (load) begin
        code_ff <= nxt_code;
      end
      cmp_ff <= rawCode[DATA_W-1 -: CMP_W];
    end
  end

  assign code   = code_ff;
  assign cmpOut = cmp_ff;
endmodule

//--- verif/adc_ctl_assertions.sv
// checker: port-level assertions for the converter control block
`timescale 1ns/10ps
module adc_ctl_assertions
  import adc_ctl_pkg::*;
(
  input wire logic                   mclk,
  input wire logic                   nrst,
  input wire logic                   hardRstPinN,
  input wire cfg_wr_t                cfgWrite,
  input wire sample_t                sampleIn,
  input wire logic                   sdoData,
  input wire logic [CFG_W-1:0]       first_configuration_word,
  input wire logic [7:0]             reference_tempco_trim,
  input wire logic                   ext_reference_select,
  input wire logic                   refOutEnable,
  input wire logic                   refDiffInput,
  input wire logic                   autoZeroPhase,
  input wire logic                   biasOn,
  input wire logic                   porDone,
  input wire logic                   sdoOut,
  input wire logic                   sdoOeN,
  input wire logic                   data_ready_pin,
  input wire logic                   dataReadyOeN,
  input wire logic [NUM_CH*DATA_W-1:0] chanCodes,
  input wire logic [NUM_CH*CMP_W-1:0]  cmpStates
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // field views must track the stored word
  AST_TRIM_FIELD: assert property (reference_tempco_trim == first_configuration_word[7:0])
    else $error("trim output differs from config bits 7:0");
  AST_REF_INT: assert property (!ext_reference_select |-> refOutEnable && !refDiffInput)
    else $error("internal reference not driven out");
  AST_REF_EXT: assert property (ext_reference_select |-> refDiffInput && !refOutEnable)
    else $error("reference pins not a differential input");
  AST_WRITE_TAKEN: assert property (hardRstPinN [*5] ##0 (cfgWrite.en && porDone)
    |-> ##2 first_configuration_word == $past(cfgWrite.data, 2))
    else $error("config write not applied");
  // sync latency is about four cycles, so judge only after five low cycles
  AST_HARD_FLOAT: assert property (!hardRstPinN [*5] |=> sdoOeN && dataReadyOeN)
    else $error("outputs driven during hard reset");
  AST_HARD_CLEAR: assert property (!hardRstPinN [*5] |=> chanCodes == '0
    && cmpStates == {NUM_CH{CMP_RESET}})
    else $error("channels not cleared in hard reset");
  AST_NO_WRITE: assert property (!hardRstPinN [*5] ##0 cfgWrite.en
    |-> ##2 first_configuration_word == CFG_RESET)
    else $error("config changed during hard reset");
  AST_BIAS_KEPT: assert property (biasOn && !hardRstPinN |=> biasOn)
    else $error("bias dropped in hard reset");
  AST_READY_PULSE: assert property ($fell(data_ready_pin) |->
    $past(sampleIn.valid) && $past(sampleIn.chan) == 3'h7 ##1 data_ready_pin)
    else $error("ready pulse without channel 7 sample or too long");
  AST_LOW_RATIO: assert property ($fell(data_ready_pin) && first_configuration_word[11:9] == 3'h0
    |-> chanCodes[7*DATA_W+:DATA_W] == ($past(sampleIn.code) & 24'hFFFF80))
    else $error("code not left-justified at lowest ratio");
  AST_AUTO_ZERO: assert property ($changed(autoZeroPhase) |=>
    !$changed(autoZeroPhase) [*7] ##1 $changed(autoZeroPhase))
    else $error("auto-zero phase not mclk/16");
  AST_SDO_COPY: assert property (!sdoOeN |-> sdoOut == $past(sdoData))
    else $error("serial out not following data");
endmodule

bind adc_reset_reference_control adc_ctl_assertions chk_u (.mclk, .nrst, .hardRstPinN,
  .cfgWrite, .sampleIn, .sdoData, .first_configuration_word, .reference_tempco_trim,
  .ext_reference_select, .refOutEnable, .refDiffInput, .autoZeroPhase, .biasOn, .porDone,
  .sdoOut, .sdoOeN, .data_ready_pin, .dataReadyOeN, .chanCodes, .cmpStates);

//--- verif/host_model.sv
// host-side model: config writes, serial data pattern, early ready filter
`timescale 1ns/10ps
module host_model
  import adc_ctl_pkg::*;
#(
  parameter int HOLDOFF = 64
)(
  input  wire logic mclk,
  input  wire logic porDone,
  input  wire logic data_ready_pin,
  output cfg_wr_t   cfgWrite,
  output logic      sdoData
);
  int sinceRst = 0;
  int keptCnt  = 0;

  initial begin
    cfgWrite = '0;
    sdoData = 1'b0;
  end
  // pattern flips every cycle so a stale copy is caught
  always @(posedge mclk) sdoData <= #2 ~sdoData;
  // pulses too soon after reset carry unsettled data, drop them
  always @(posedge mclk) begin
    sinceRst <= porDone ? sinceRst + 1 : 0;
    if (data_ready_pin === 1'b0 && sinceRst > HOLDOFF) keptCnt <= keptCnt + 1;
  end
  // one-cycle write strobe, launched just after an edge
  task automatic write_cfg(input logic [CFG_W-1:0] d);
    cfgWrite = '{1'b1, d};
    @(posedge mclk);
    #2;
    cfgWrite.en = 1'b0;
  endtask
endmodule

//--- verif/adc_reset_reference_control_tb.sv
// testbench: config rows, power-on, hard reset and settling cases
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module adc_reset_reference_control_tb;
  import adc_ctl_pkg::*;
  typedef struct {
    logic [23:0] cfg;
    logic [23:0] code;
    logic [23:0] expCode;
    logic [7:0]  trim;
    logic        ext;
  } row_t;
  logic mclk, nrst, hardRstPinN, avddGood, dvddGood, sdoData;
  cfg_wr_t cfgWrite;
  sample_t sampleIn;
  logic [CFG_W-1:0] cfgWord;
  logic [7:0] trim;
  logic extSel, refOut, refDiff, azPhase, biasOn, porDone, sdoOut, sdoOeN, rdyN, rdyOeN;
  logic [NUM_CH*DATA_W-1:0] chanCodes;
  logic [NUM_CH*CMP_W-1:0] cmpStates;
  int error_cnt = 0;
  int tests_run = 0;
  int i;
  // two ratio-3 rows then two lowest-ratio rows
  row_t rows [4] = '{'{24'h0006FF, 24'h123456, 24'h123456, 8'hFF, 1'b0},
                     '{24'h000742, 24'h800001, 24'h800001, 8'h42, 1'b1},
                     '{24'h000150, 24'h7FFFFF, 24'h7FFF80, 8'h50, 1'b1},
                     '{24'h000000, 24'hFFFFFF, 24'hFFFF80, 8'h00, 1'b0}};

  adc_reset_reference_control #(.PORCYCLES(20)) dut_u (.mclk, .nrst, .hardRstPinN,
    .avddGood, .dvddGood, .cfgWrite, .sampleIn, .sdoData,
    .first_configuration_word(cfgWord), .reference_tempco_trim(trim),
    .ext_reference_select(extSel), .refOutEnable(refOut), .refDiffInput(refDiff),
    .autoZeroPhase(azPhase), .biasOn, .porDone, .sdoOut, .sdoOeN,
    .data_ready_pin(rdyN), .dataReadyOeN(rdyOeN), .chanCodes, .cmpStates);
  host_model host_u (.mclk, .porDone, .data_ready_pin(rdyN), .cfgWrite, .sdoData);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  // channel 7 sample; return in the one cycle where code and ready pulse both stand
  task automatic send_sample(input logic [23:0] c);
    sampleIn = '{1'b1, 3'h7, c};
    tick(1);
    sampleIn.valid = 1'b0;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #250000;
    error_cnt++;
    give_verdict;
  end
  initial begin
    nrst = 1'b0;
    hardRstPinN = 1'b1;
    avddGood = 1'b0;
    dvddGood = 1'b0;
    sampleIn = '0;
    tick(2);
    `CHK("trim reset", 8'h50, trim)
    `CHK("cfg reset", CFG_RESET, cfgWord)
    nrst = 1'b1;
    avddGood = 1'b1;
    tick(40);
    `CHK("por one supply", 1'b0, porDone)
    dvddGood = 1'b1;
    for (i = 0; i < 100 && porDone !== 1'b1; i++) tick(1);
    `CHK("por done", 1'b1, porDone)
    tick(800);
    foreach (rows[k]) begin
      host_u.write_cfg(rows[k].cfg);
      tick(2);
      `CHK("trim", rows[k].trim, trim)
      `CHK("ext", rows[k].ext, extSel)
      `CHK("ref out", ~rows[k].ext, refOut)
      send_sample(rows[k].code);
      `CHK("code", rows[k].expCode, chanCodes[7*DATA_W+:DATA_W])
      `CHK("ready", 1'b0, rdyN)
    end
    // hard reset with a write landing inside it
    hardRstPinN = 1'b0;
    tick(6);
    host_u.write_cfg(24'h0007AA);
    tick(2);
    `CHK("cfg hard", CFG_RESET, cfgWord)
    `CHK("codes hard", '0, chanCodes)
    `CHK("cmp hard", {NUM_CH{CMP_RESET}}, cmpStates)
    `CHK("float", 2'b11, {sdoOeN, rdyOeN})
    `CHK("bias", 1'b1, biasOn)
    hardRstPinN = 1'b1;
    tick(6);
    send_sample(24'h123456);
    `CHK("early sample", 1'b1, rdyN)
    `CHK("early code", CODE_ZERO, chanCodes[7*DATA_W+:DATA_W])
    tick(800);
    send_sample(24'h7FFFFF);
    `CHK("full width", 24'h7FFFFF, chanCodes[7*DATA_W+:DATA_W])
    tick(1);
    `CHK("kept ready", 5, host_u.keptCnt)
    give_verdict;
  end
endmodule
